// ### src/pulse_counter_pkg.sv
// constants, field layout and mode encodings for the four-input pulse counter
// assumes a 100 MHz system clock and a plain strobe register port
// Contract
// - frequency mode: hertz per selectable window
// - totalize counts rising or falling edges
// - totalize wraps at cpr, zero means 32-bit
// - level clear holds totalizer at zero
// - inputs 3/4 edge-reset totalizers 1/2
// - hardware totalize reset within 100 us
// - compare drives shared output when count>=preset
// - shared outputs select software, pwm, compare
// - preset changes live; zero forces output low
// - width-high measured in microsecond ticks
// - width-low measured in microsecond ticks
// - period between like edges in microseconds
// - pulse result held until next completes
// - quad pairs inputs 1/2 and 3/4
// - four counts per cycle, reverse counts down
// - direction mode selects up or down
// - quad wraps at cpr both ways
// - software clear and set per quad
// - marker only while quad one active
// - async marker edge clears quad count
// - sync marker loads zero or cpr-1
// - marker sampled within 50 us
package pulse_counter_pkg;
  localparam int ACC_W = 32;
  localparam int ADDR_W = 5;
  localparam int NCH = 4;

  typedef enum logic [2:0] {
    MODE_OFF, MODE_FREQ, MODE_TOTAL, MODE_PULSE, MODE_QUAD, MODE_TRST, MODE_MARKER
  } mode_t;

  typedef enum logic [1:0] {OUT_SOFT, OUT_PWM, OUT_COUNT} out_sel_t;

  // register word addresses
  localparam logic [ADDR_W-1:0] REG_CFG0 = 5'h00;
  localparam logic [ADDR_W-1:0] REG_CPR0 = 5'h04;
  localparam logic [ADDR_W-1:0] REG_PRESET0 = 5'h08;
  localparam logic [ADDR_W-1:0] REG_PRESET1 = 5'h09;
  localparam logic [ADDR_W-1:0] REG_CTRL = 5'h0a;
  localparam logic [ADDR_W-1:0] REG_ACC0 = 5'h0c;

  // channel configuration fields
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_SUB_LSB = 3;
  localparam int CFG_MK_SYNC = 6;
  localparam int CFG_MK_HIGH = 7;
  localparam int CFG_MK_PHB = 8;
  localparam int CFG_EDGE_LSB = 9;
  localparam logic [ACC_W-1:0] CFG_RESET = 32'h0000_0000;

  // control register fields
  localparam int CTRL_CLR_LSB = 0;
  localparam int CTRL_SEL1_LSB = 4;
  localparam int CTRL_SEL2_LSB = 6;
  localparam int CTRL_SW_LSB = 8;
  localparam logic [ACC_W-1:0] CTRL_RESET = 32'h0000_0000;

  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;

  localparam logic [1:0] PULSE_WIDTH_HIGH = 2'h0;
  localparam logic [1:0] PULSE_WIDTH_LOW = 2'h1;
  localparam logic [1:0] PULSE_PERIOD_RISE = 2'h2;
  localparam logic [1:0] PULSE_PERIOD_FALL = 2'h3;

  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int US_NS = 1000;
  localparam int US_CYCLES = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int US_PER_MS = 1000;
  localparam int RESET_LATENCY_US = 100;
  localparam int RESET_LATENCY_CYCLES = RESET_LATENCY_US * US_NS / CLK_PERIOD_NS;
  localparam int MARKER_SAMPLE_US = 50;
  localparam int MARKER_SAMPLE_CYCLES = MARKER_SAMPLE_US * US_NS / CLK_PERIOD_NS;

  // frequency sample windows in ms, and the factor that turns edges into hertz
  localparam logic [15:0] WIN_MS0 = 16'h03e8;
  localparam logic [15:0] WIN_MS1 = 16'h01f4;
  localparam logic [15:0] WIN_MS2 = 16'h00fa;
  localparam logic [15:0] WIN_MS3 = 16'h0064;
  localparam logic [3:0] WIN_MUL0 = 4'h1;
  localparam logic [3:0] WIN_MUL1 = 4'h2;
  localparam logic [3:0] WIN_MUL2 = 4'h4;
  localparam logic [3:0] WIN_MUL3 = 4'ha;
endpackage

// ### src/multi_mode_pulse_counter_quad.sv
// four-input counter: frequency, totalize and pulse per input, quadrature per input pair
// assumes inputs are debounced pulse sources; pwm generation lives outside
`timescale 1ns/1ns
module multi_mode_pulse_counter_quad #(
  parameter int US_CYCLES_P = pulse_counter_pkg::US_CYCLES, // clocks per microsecond
  parameter int US_PER_MS_P = pulse_counter_pkg::US_PER_MS // microseconds per millisecond
) (
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset, high
  input wire logic [pulse_counter_pkg::NCH-1:0] cnt_in, // counter input pins
  input wire logic [1:0] pwm_in, // pwm waveforms from outside
  input wire logic [pulse_counter_pkg::ADDR_W-1:0] addr, // register word address
  input wire logic [pulse_counter_pkg::ACC_W-1:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [pulse_counter_pkg::ACC_W-1:0] rdata, // read data, cycle after rd
  output logic shared_output_one, // physical output one
  output logic shared_output_two // physical output two
);
  import pulse_counter_pkg::*;

  localparam int RST_LAT_MAX = 2;

  logic [ACC_W-1:0] cfg_q [NCH];
  logic [ACC_W-1:0] cpr_q [NCH];
  logic [ACC_W-1:0] compare_preset_q [2];
  logic [ACC_W-1:0] ctrl_q;
  logic [ACC_W-1:0] acc_q [NCH];
  logic [ACC_W-1:0] rdata_q;
  logic [ACC_W-1:0] edge_cnt_q [NCH];
  logic [ACC_W-1:0] pw_q [NCH];
  logic [NCH-1:0] armed_q;
  logic [15:0] win_cnt_q [NCH];
  logic [15:0] us_cnt_q;
  logic [15:0] ms_cnt_q;
  logic [NCH-1:0] sync1_q, sync2_q, prev_q;
  logic out_one_q, out_two_q;

  mode_t mode [NCH];
  logic [NCH-1:0] rise, fall, win_done, p_start, p_end;
  logic [1:0] trst_hit, cmp_hit;
  logic [3:0] software_clear_bits;
  logic us_tick, ms_tick, mk_zero, mk_top, mk_async;

  function automatic logic edge_hit(input logic r, input logic f, input logic [1:0] code);
    case (code)
      EDGE_RISE: edge_hit = r;
      EDGE_FALL: edge_hit = f;
      EDGE_BOTH: edge_hit = r | f;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  function automatic logic [15:0] win_len(input logic [1:0] sel);
    case (sel)
      2'h0: win_len = WIN_MS0;
      2'h1: win_len = WIN_MS1;
      2'h2: win_len = WIN_MS2;
      default: win_len = WIN_MS3;
    endcase
  endfunction

  function automatic logic [ACC_W-1:0] freq_scale(input logic [ACC_W-1:0] n,
                                                  input logic [1:0] sel);
    logic [3:0] m;
    case (sel)
      2'h0: m = WIN_MUL0;
      2'h1: m = WIN_MUL1;
      2'h2: m = WIN_MUL2;
      default: m = WIN_MUL3;
    endcase
    freq_scale = ACC_W'(n * m);
  endfunction

  // count up, back to zero on the count after cpr-1; zero cpr wraps at 32 bits
  function automatic logic [ACC_W-1:0] inc_wrap(input logic [ACC_W-1:0] a,
                                                input logic [ACC_W-1:0] c);
    if (c != '0 && a == c - 1'b1)
      inc_wrap = '0;
    else
      inc_wrap = a + 1'b1;
  endfunction

  // below zero loads cpr-1, which is all ones when cpr is zero
  function automatic logic [ACC_W-1:0] dec_wrap(input logic [ACC_W-1:0] a,
                                                input logic [ACC_W-1:0] c);
    if (a == '0)
      dec_wrap = c - 1'b1;
    else
      dec_wrap = a - 1'b1;
  endfunction

  // {up, down} in the sense where phase 1 leads phase 2
  function automatic logic [1:0] quad_step(input logic [1:0] pab, input logic [1:0] cab);
    logic ar, af, br, bf;
    ar = ~pab[1] & cab[1];
    af = pab[1] & ~cab[1];
    br = ~pab[0] & cab[0];
    bf = pab[0] & ~cab[0];
    quad_step[1] = (ar & ~cab[0]) | (br & cab[1]) | (af & cab[0]) | (bf & ~cab[1]);
    quad_step[0] = (ar & cab[0]) | (br & ~cab[1]) | (af & ~cab[0]) | (bf & cab[1]);
  endfunction

  // first stage feeds only the second; edges come from the second and third
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q <= '0;
    end
    else
    begin
      sync1_q <= cnt_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  assign rise = sync2_q & ~prev_q;
  assign fall = ~sync2_q & prev_q;

  // microsecond and millisecond ticks
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      us_cnt_q <= '0;
      ms_cnt_q <= '0;
    end
    else
    begin
      us_cnt_q <= us_tick ? '0 : us_cnt_q + 1'b1;
      if (ms_tick)
        ms_cnt_q <= '0;
      else if (us_tick)
        ms_cnt_q <= ms_cnt_q + 1'b1;
    end
  end

  assign us_tick = us_cnt_q == 16'(US_CYCLES_P - 1);
  assign ms_tick = us_tick && ms_cnt_q == 16'(US_PER_MS_P - 1);
  assign software_clear_bits = ctrl_q[CTRL_CLR_LSB +: 4];

  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      mode[i] = mode_t'(cfg_q[i][CFG_MODE_LSB +: 3]);
      win_done[i] = ms_tick && win_cnt_q[i] == win_len(cfg_q[i][CFG_SUB_LSB +: 2]) - 1'b1;
      case (cfg_q[i][CFG_SUB_LSB +: 2])
        PULSE_WIDTH_HIGH:
        begin
          p_start[i] = rise[i];
          p_end[i] = fall[i];
        end
        PULSE_WIDTH_LOW:
        begin
          p_start[i] = fall[i];
          p_end[i] = rise[i];
        end
        PULSE_PERIOD_RISE:
        begin
          p_start[i] = rise[i];
          p_end[i] = rise[i];
        end
        default:
        begin
          p_start[i] = fall[i];
          p_end[i] = fall[i];
        end
      endcase
    end
  end

  // inputs three and four reset totalizers one and two, only if those totalize
  always_comb
  begin
    for (int k = 0; k < 2; k++)
      trst_hit[k] = mode[k+2] == MODE_TRST && mode[k] == MODE_TOTAL &&
                    edge_hit(rise[k+2], fall[k+2], cfg_q[k+2][CFG_EDGE_LSB +: 2]);
  end

  // marker on input three acts on quad one; the marker level is read on the
  // same clock as the phase edge, well inside the sampling limit
  always_comb
  begin
    logic ph_r, ph_f, lvl_ok, fall_mode, active;
    active = mode[0] == MODE_QUAD && mode[2] == MODE_MARKER;
    ph_r = cfg_q[2][CFG_MK_PHB] ? rise[1] : rise[0];
    ph_f = cfg_q[2][CFG_MK_PHB] ? fall[1] : fall[0];
    lvl_ok = sync2_q[2] == cfg_q[2][CFG_MK_HIGH];
    fall_mode = cfg_q[2][CFG_EDGE_LSB +: 2] == EDGE_FALL;
    mk_async = active && !cfg_q[2][CFG_MK_SYNC] &&
               edge_hit(rise[2], fall[2], cfg_q[2][CFG_EDGE_LSB +: 2]);
    mk_zero = active && cfg_q[2][CFG_MK_SYNC] && lvl_ok &&
              (fall_mode ? ph_f : ph_r);
    mk_top = active && cfg_q[2][CFG_MK_SYNC] && lvl_ok &&
             (fall_mode ? ph_r : ph_f);
  end

  // frequency window and edge counting
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < NCH; i++)
    begin
      if (rst || mode[i] != MODE_FREQ)
      begin
        win_cnt_q[i] <= '0;
        edge_cnt_q[i] <= '0;
      end
      else
      begin
        if (ms_tick)
          win_cnt_q[i] <= win_done[i] ? '0 : win_cnt_q[i] + 1'b1;
        // an edge landing on the closing cycle opens the next window
        edge_cnt_q[i] <= win_done[i] ? ACC_W'(rise[i]) : edge_cnt_q[i] + ACC_W'(rise[i]);
      end
    end
  end

  // pulse timing in microsecond ticks, saturating rather than wrapping
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < NCH; i++)
    begin
      if (rst || mode[i] != MODE_PULSE)
      begin
        pw_q[i] <= '0;
        armed_q[i] <= 1'b0;
      end
      else if (p_start[i])
      begin
        pw_q[i] <= '0;
        armed_q[i] <= 1'b1;
      end
      else if (us_tick && pw_q[i] != '1)
        pw_q[i] <= pw_q[i] + 1'b1;
    end
  end

  // accumulators
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < NCH; i++)
    begin
      logic [1:0] st;
      logic up, dn;
      st = quad_step({prev_q[i], prev_q[i|1]}, {sync2_q[i], sync2_q[i|1]});
      up = cfg_q[i][CFG_SUB_LSB] ? st[0] : st[1];
      dn = cfg_q[i][CFG_SUB_LSB] ? st[1] : st[0];
      if (rst || (i[0] && mode[i & 2] == MODE_QUAD))
        acc_q[i] <= '0;
      else
      begin
        case (mode[i])
          MODE_FREQ:
            if (win_done[i])
              acc_q[i] <= freq_scale(edge_cnt_q[i], cfg_q[i][CFG_SUB_LSB +: 2]);
          MODE_TOTAL:
            if (software_clear_bits[i] || (i < 2 && trst_hit[i & 1]))
              acc_q[i] <= '0;
            else if (edge_hit(rise[i], fall[i], {1'b0, cfg_q[i][CFG_SUB_LSB]}))
              acc_q[i] <= inc_wrap(acc_q[i], cpr_q[i]);
          MODE_PULSE:
            if (p_end[i] && armed_q[i])
              acc_q[i] <= pw_q[i];
          MODE_QUAD:
            if (i[0])
              acc_q[i] <= '0;
            else if (software_clear_bits[i])
              acc_q[i] <= '0;
            else if (software_clear_bits[i|1])
              acc_q[i] <= cpr_q[i] - 1'b1;
            else if (i == 0 && (mk_async || mk_zero))
              acc_q[i] <= '0;
            else if (i == 0 && mk_top)
              acc_q[i] <= cpr_q[i] - 1'b1;
            else if (up)
              acc_q[i] <= inc_wrap(acc_q[i], cpr_q[i]);
            else if (dn)
              acc_q[i] <= dec_wrap(acc_q[i], cpr_q[i]);
          default:
            acc_q[i] <= '0;
        endcase
      end
    end
  end

  // register writes
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        cfg_q[i] <= CFG_RESET;
        cpr_q[i] <= '0;
      end
      compare_preset_q[0] <= '0;
      compare_preset_q[1] <= '0;
      ctrl_q <= CTRL_RESET;
    end
    else if (wr)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        if (addr == REG_CFG0 + ADDR_W'(i))
          cfg_q[i] <= wdata;
        if (addr == REG_CPR0 + ADDR_W'(i))
          cpr_q[i] <= wdata;
      end
      if (addr == REG_PRESET0)
        compare_preset_q[0] <= wdata;
      if (addr == REG_PRESET1)
        compare_preset_q[1] <= wdata;
      if (addr == REG_CTRL)
        ctrl_q <= wdata;
    end
  end

  // read data valid only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk)
  begin
    if (rst || !rd)
      rdata_q <= '0;
    else
    begin
      rdata_q <= '0;
      for (int i = 0; i < NCH; i++)
      begin
        if (addr == REG_CFG0 + ADDR_W'(i))
          rdata_q <= cfg_q[i];
        if (addr == REG_CPR0 + ADDR_W'(i))
          rdata_q <= cpr_q[i];
        if (addr == REG_ACC0 + ADDR_W'(i))
          rdata_q <= acc_q[i];
      end
      if (addr == REG_PRESET0)
        rdata_q <= compare_preset_q[0];
      if (addr == REG_PRESET1)
        rdata_q <= compare_preset_q[1];
      if (addr == REG_CTRL)
        rdata_q <= ctrl_q;
    end
  end

  // compare against preset; a zero preset disables the compare
  always_comb
  begin
    for (int k = 0; k < 2; k++)
      cmp_hit[k] = mode[k] == MODE_TOTAL && compare_preset_q[k] != '0 &&
                   acc_q[k] >= compare_preset_q[k];
  end

  // shared output source select, registered so the pins never glitch
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      out_one_q <= 1'b0;
      out_two_q <= 1'b0;
    end
    else
    begin
      case (out_sel_t'(ctrl_q[CTRL_SEL1_LSB +: 2]))
        OUT_SOFT: out_one_q <= ctrl_q[CTRL_SW_LSB];
        OUT_PWM: out_one_q <= pwm_in[0];
        OUT_COUNT: out_one_q <= cmp_hit[0];
        default: out_one_q <= 1'b0;
      endcase
      case (out_sel_t'(ctrl_q[CTRL_SEL2_LSB +: 2]))
        OUT_SOFT: out_two_q <= ctrl_q[CTRL_SW_LSB+1];
        OUT_PWM: out_two_q <= pwm_in[1];
        OUT_COUNT: out_two_q <= cmp_hit[1];
        default: out_two_q <= 1'b0;
      endcase
    end
  end

  assign rdata = rdata_q;
  assign shared_output_one = out_one_q;
  assign shared_output_two = out_two_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence tot_edge0;
    mode[0] == MODE_TOTAL && !software_clear_bits[0] && !trst_hit[0] &&
    edge_hit(rise[0], fall[0], {1'b0, cfg_q[0][CFG_SUB_LSB]});
  endsequence

  sequence quad_quiet0;
    mode[0] == MODE_QUAD && software_clear_bits[1:0] == 2'b00 && !mk_async && !mk_zero && !mk_top;
  endsequence

  chk_us_period: assert property (us_tick |=> (!us_tick)[*8])
    else $error("microsecond tick repeats too soon");
  chk_clear_hold: assert property ((mode[0] == MODE_TOTAL && software_clear_bits[0])[*2]
    |=> acc_q[0] == '0)
    else $error("cleared totalizer not at zero");
  chk_tot_step: assert property (tot_edge0 and cpr_q[0] == '0
    |=> acc_q[0] == $past(acc_q[0]) + 1'b1)
    else $error("totalizer missed a count");
  chk_tot_wrap: assert property (tot_edge0 and cpr_q[0] != '0 and acc_q[0] == cpr_q[0] - 1'b1
    |=> acc_q[0] == '0)
    else $error("totalizer did not wrap at cpr");
  chk_hw_reset: assert property (trst_hit[0] |-> ##[1:RST_LAT_MAX] acc_q[0] == '0)
    else $error("hardware reset not applied in time");
  chk_cmp_high: assert property (ctrl_q[CTRL_SEL1_LSB +: 2] == OUT_COUNT && mode[0] == MODE_TOTAL
    && compare_preset_q[0] != '0 && acc_q[0] >= compare_preset_q[0] |=> shared_output_one)
    else $error("compare output not high at preset");
  chk_cmp_zero: assert property (ctrl_q[CTRL_SEL1_LSB +: 2] == OUT_COUNT
    && compare_preset_q[0] == '0 |=> !shared_output_one)
    else $error("zero preset must keep output low");
  chk_pulse_hold: assert property ((mode[0] == MODE_PULSE && !p_end[0]) ##1 mode[0] == MODE_PULSE
    |-> $stable(acc_q[0]))
    else $error("pulse result changed without a new measurement");
  chk_quad_clear: assert property (mode[0] == MODE_QUAD && software_clear_bits[0]
    |=> acc_q[0] == '0)
    else $error("quad clear failed");
  chk_quad_set: assert property (mode[0] == MODE_QUAD && !software_clear_bits[0]
    && software_clear_bits[1] |=> acc_q[0] == $past(cpr_q[0]) - 1'b1)
    else $error("quad set failed");
  chk_marker_async: assert property (mode[0] == MODE_QUAD && mk_async
    && !software_clear_bits[1] |=> acc_q[0] == '0)
    else $error("async marker did not clear count");
  chk_quad_up: assert property (quad_quiet0 and cpr_q[0] == '0 and !cfg_q[0][CFG_SUB_LSB]
    and quad_step({prev_q[0], prev_q[1]}, {sync2_q[0], sync2_q[1]}) == 2'b10
    |=> acc_q[0] == $past(acc_q[0]) + 1'b1)
    else $error("quadrature step not counted up");
endmodule

// ### tb/pulse_source.sv
// pulse and quadrature source model standing at the four counter pins
// assumes the bench calls its tasks from one process at a time per pin group
`timescale 1ns/1ns
module pulse_source (
  input wire logic clk, // system clock
  output logic [3:0] pins // counter input pins, bit0 is input one
);
  logic [1:0] ph;

  initial
  begin
    pins = 4'h0;
    ph = 2'h0;
  end

  // callers keep widths at three clocks or more, else the sync flops can drop a phase
  task pulse(input int ch, input int hi, input int lo);
    @(posedge clk);
    pins[ch] <= 1'b1;
    repeat (hi) @(posedge clk);
    pins[ch] <= 1'b0;
    repeat (lo - 1) @(posedge clk);
  endtask

  // holds one pin at a level, long enough for the sync flops to pass it
  task level(input int ch, input logic v);
    @(posedge clk);
    pins[ch] <= v;
    repeat (4) @(posedge clk);
  endtask

  // gray steps on inputs one and two: only one phase moves per step
  task qstep(input int up);
    ph = (up != 0) ? ph + 2'h1 : ph - 2'h1;
    @(posedge clk);
    pins[1:0] <= {ph[1], ph[1] ^ ph[0]};
    repeat (4) @(posedge clk);
  endtask
endmodule

// ### tb/tb_top.sv
// self-checking bench for the four-input pulse counter
// assumes the pulse source model drives the pins and the bench owns the register port
`timescale 1ns/1ns
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
  import pulse_counter_pkg::*;
  localparam int US = 10;
  localparam int LIMIT = 40000;
  logic clk, rst, wr, rd, out1, out2;
  logic [NCH-1:0] cnt_in;
  logic [1:0] pwm_in;
  logic [ADDR_W-1:0] addr;
  logic [ACC_W-1:0] wdata, rdata, d, d0;
  int err_total, checked, cyc, n, acc_m;
  int exp_q[$];
  logic [ADDR_W-1:0] zero_q[$];

  multi_mode_pulse_counter_quad #(.US_CYCLES_P(US), .US_PER_MS_P(4)) uut (
    .clk(clk), .rst(rst), .cnt_in(cnt_in), .pwm_in(pwm_in), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .shared_output_one(out1), .shared_output_two(out2));
  pulse_source src (.clk(clk), .pins(cnt_in));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      err_total++;
      test_done();
    end
  end

  task test_done();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task idle(input int c);
    repeat (c) @(posedge clk);
  endtask

  task wreg(input logic [ADDR_W-1:0] a, input logic [ACC_W-1:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task rreg(input logic [ADDR_W-1:0] a, output logic [ACC_W-1:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    v = rdata;
  endtask

  task ck_acc(input int ch, input int e);
    idle(6);
    rreg(ADDR_W'(REG_ACC0 + ch), d);
    `CHK(d, ACC_W'(e))
  endtask

  // microsecond results may land one tick either side of the prescaler phase
  task near(input int ch, input int e, input int tol);
    idle(10);
    rreg(ADDR_W'(REG_ACC0 + ch), d);
    `CHK(d >= ACC_W'(e - tol) && d <= ACC_W'(e + tol), 1'b1)
  endtask

  initial
  begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = '0;
    pwm_in = 2'h0;
    void'($urandom(32'h2a3a));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    wreg(REG_ACC0, $urandom());
    zero_q = '{REG_CFG0, REG_CTRL, REG_ACC0, 5'h1f};
    foreach (zero_q[k])
    begin
      rreg(zero_q[k], d);
      `CHK(d, 32'h0000_0000)
    end
    `CHK({out1, out2}, 2'b00)
    $display("test reset finished");

    wreg(REG_CFG0, 32'h2);
    wreg(REG_CPR0, 32'h5);
    wreg(ADDR_W'(REG_CFG0 + 1), 32'ha);
    n = $urandom_range(12, 3);
    repeat (n) src.pulse(0, $urandom_range(6, 3), $urandom_range(6, 3));
    ck_acc(0, n % 5);
    repeat (n) src.pulse(1, 3, 4);
    ck_acc(1, n);
    wreg(REG_CTRL, 32'h1);
    repeat (3) src.pulse(0, 4, 4);
    ck_acc(0, 0);
    wreg(REG_CTRL, 32'h0);
    repeat (2) src.pulse(0, 4, 4);
    ck_acc(0, 2);
    $display("test totalize finished");

    wreg(REG_CPR0, 32'h0);
    wreg(REG_PRESET0, 32'h4);
    wreg(REG_CTRL, 32'h60);
    idle(8);
    `CHK(out1, 1'b0)
    repeat (2) src.pulse(0, 4, 4);
    idle(8);
    `CHK(out1, 1'b1)
    wreg(REG_PRESET0, 32'h0);
    idle(4);
    `CHK(out1, 1'b0)
    wreg(REG_CTRL, 32'h50);
    repeat (4)
    begin
      pwm_in <= 2'($urandom());
      idle(3);
      `CHK({out2, out1}, pwm_in)
    end
    wreg(REG_CTRL, 32'h200);
    idle(3);
    `CHK({out1, out2}, 2'b01)
    wreg(ADDR_W'(REG_CFG0 + 2), 32'h5);
    src.pulse(2, 4, 4);
    ck_acc(0, 0);
    $display("test compare and reset finished");

    exp_q = '{5, 3, 8, 8};
    for (int s = 0; s < 4; s++)
    begin
      wreg(REG_CFG0, 32'h3 | (s << 3));
      repeat (3) src.pulse(0, 5 * US, 3 * US);
      near(0, exp_q[s], 1);
      d0 = d;
      idle(60);
      rreg(REG_ACC0, d);
      `CHK(d, d0)
    end
    $display("test pulse finished");

    wreg(ADDR_W'(REG_CFG0 + 2), 32'h0);
    wreg(REG_CFG0, 32'h4);
    wreg(REG_CPR0, 32'h8);
    wreg(REG_CTRL, 32'h1);
    wreg(REG_CTRL, 32'h0);
    ck_acc(0, 0);
    acc_m = 0;
    n = $urandom_range(7, 3);
    repeat (n)
    begin
      src.qstep(1);
      acc_m = (acc_m + 1) % 8;
    end
    ck_acc(0, acc_m);
    repeat (n + 3)
    begin
      src.qstep(0);
      acc_m = (acc_m + 7) % 8;
    end
    ck_acc(0, acc_m);
    ck_acc(1, 0);
    wreg(REG_CTRL, 32'h2);
    wreg(REG_CTRL, 32'h0);
    ck_acc(0, 7);
    src.qstep(1);
    ck_acc(0, 0);
    wreg(REG_CFG0, 32'hc);
    src.qstep(1);
    ck_acc(0, 7);
    wreg(REG_CFG0, 32'h4);
    wreg(ADDR_W'(REG_CFG0 + 2), 32'h6);
    repeat (3) src.qstep(1);
    ck_acc(0, 2);
    src.pulse(2, 4, 4);
    ck_acc(0, 0);
    // marker held high: a falling phase one loads the top, a rising one clears
    wreg(ADDR_W'(REG_CFG0 + 2), 32'hc6);
    src.level(2, 1'b1);
    src.qstep(1);
    ck_acc(0, 7);
    repeat (2) src.qstep(1);
    ck_acc(0, 0);
    src.level(2, 1'b0);
    repeat (2) src.qstep(1);
    ck_acc(0, 2);
    $display("test quadrature finished");

    // 100 ms window shrinks to 4000 clocks; a 40 clock period reads as 1000 hertz
    wreg(REG_CFG0, 32'h19);
    fork
      repeat (300) src.pulse(0, 20, 20);
      begin
        idle(9500);
        near(0, 1000, 20);
      end
    join
    $display("test frequency finished");
    test_done();
  end
endmodule
